// *** verilog/tkc_ctrl_top.sv ***
//
// Contract
// - Internal reference used when select bit set
// - Settle field picks 0/100/500/1000 us
// - Conversions wait for settled internal reference
// - Power-down bit switches reference off between conversions
// - External reference keeps internal one off
// - Auto power-down powers reference per conversion
// - Voltage bit picks 1.2 V or 2.5 V
// - Reference fields read back as written
// - Precharge field selects eight precharge times
// - Precharge first, then sense touch
// - Sense field sets sense phase length before touch sample
// - Key-pressed bit is inverse of interrupt
// - Scan bit reads 0 busy, 1 idle
// - Writing 0 runs continuous keypad scans
// - Writing 1 halts scans and conversions immediately
// - Debounce field selects 2 to 120 ms
// - Writing 1 to scan bit releases interrupt
`timescale 1ns/10ps
`default_nettype none
module tkc_ctrl_top #(
   parameter tkc_pkg::tkc_tab4_t SETTLE_CYC_P = tkc_pkg::SETTLE_CYC,
   parameter tkc_pkg::tkc_tab8_t PRE_CYC_P    = tkc_pkg::PRE_CYC,
   parameter tkc_pkg::tkc_tab8_t SNS_CYC_P    = tkc_pkg::SNS_CYC,
   parameter tkc_pkg::tkc_tab8_t KEY_DB_CYC_P = tkc_pkg::KEY_DB_CYC
) (
   // Clock and reset
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        RST_N_I,
   // Register port
   input  wire logic [tkc_pkg::PAGE_W-1:0]  REG_PAGE_I,
   input  wire logic [tkc_pkg::ADDR_W-1:0]  REG_ADDR_I,
   input  wire logic                        REG_WR_I,
   input  wire logic                        REG_RD_I,
   input  wire logic [tkc_pkg::DATA_W-1:0]  REG_WDATA_I,
   output logic      [tkc_pkg::DATA_W-1:0]  REG_RDATA_O,
   output logic                             REG_RVALID_O,
   // Conversion engine
   input  wire logic                        CONV_REQ_I,
   output logic                             CONV_GO_O,
   output logic                             CONV_ABORT_O,
   // Reference
   output logic                             REF_INT_SEL_O,
   output logic                             REF_PWR_ON_O,
   output logic                             REF_2V5_O,
   // Touch detect
   input  wire logic                        TOUCH_REQ_I,
   input  wire logic                        TOUCH_SENSE_I,
   output logic                             PRECHARGE_O,
   output logic                             SENSE_O,
   output logic                             TOUCH_DET_O,
   // Keypad
   input  wire logic                        KEY_DOWN_I,
   input  wire logic                        KEY_DATA_READ_I,
   output logic                             KEY_IRQ_N_O
);
   import tkc_pkg::*;

   logic                rst_meta_q;
   logic                rst_n;
   logic [1:0]          pin_meta_q;
   logic [1:0]          pin_sync_q;
   logic                key_down;
   logic                sense_pin;
   logic                key_sel;
   logic                ref_sel;
   logic                tim_sel;
   logic                key_wr;
   logic                ref_wr;
   logic                tim_wr;
   logic                scan_stop_wr;
   logic                ref_int_q;
   logic [SETTLE_W-1:0] ref_settle_q;
   logic                ref_pdn_q;
   logic                ref_vsel_q;
   logic [SEL_W-1:0]    pre_sel_q;
   logic [SEL_W-1:0]    sns_sel_q;
   logic [SEL_W-1:0]    key_db_q;
   logic                scan_stop_q;
   logic [DATA_W-1:0]   rdata_q;
   logic                rvalid_q;
   logic                need_ref;
   tkc_ref_st_t         ref_st_q;
   tkc_ref_st_t         ref_d;
   logic                ref_pwr_q;
   logic                conv_go_q;
   logic                abort_q;
   tkc_td_st_t          td_q;
   tkc_td_st_t          td_d;
   logic                pre_on_q;
   logic                sns_on_q;
   logic                touch_q;
   logic                ks_busy;
   logic                key_irq_n;

   tkc_tmr_if ref_tmr ();
   tkc_tmr_if td_tmr ();

   // Page and offset match, shared by the write and read paths
   function automatic logic reg_hit(input logic [PAGE_W-1:0] pg,
                                    input logic [ADDR_W-1:0] ad,
                                    input logic [ADDR_W-1:0] want);
      return (pg == REG_PAGE) && (ad == want);
   endfunction

   // Reset release through two flops
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // Keypad and sense pins arrive unsynchronised
   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else begin
         pin_meta_q <= {TOUCH_SENSE_I, KEY_DOWN_I};
         pin_sync_q <= pin_meta_q;
      end
   end
   assign key_down  = pin_sync_q[0];
   assign sense_pin = pin_sync_q[1];

   assign key_sel = reg_hit(REG_PAGE_I, REG_ADDR_I, KEY_CTRL_ADDR);
   assign ref_sel = reg_hit(REG_PAGE_I, REG_ADDR_I, REF_CTRL_ADDR);
   assign tim_sel = reg_hit(REG_PAGE_I, REG_ADDR_I, TOUCH_TIM_ADDR);
   assign key_wr  = REG_WR_I && key_sel;
   assign ref_wr  = REG_WR_I && ref_sel;
   assign tim_wr  = REG_WR_I && tim_sel;
   assign scan_stop_wr = key_wr && REG_WDATA_I[SCAN_STOP_BIT];

   // Writable fields; reserved bits are simply not stored
   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         ref_int_q    <= REF_INT_RST;
         ref_settle_q <= REF_SETTLE_RST;
         ref_pdn_q    <= REF_PDN_RST;
         ref_vsel_q   <= REF_VSEL_RST;
         pre_sel_q    <= PRE_RST;
         sns_sel_q    <= SNS_RST;
         key_db_q     <= KEY_DB_RST;
         scan_stop_q  <= SCAN_STOP_RST;
      end else begin
         if (ref_wr) begin
            ref_int_q    <= REG_WDATA_I[REF_INT_BIT];
            ref_settle_q <= REG_WDATA_I[REF_SETTLE_LSB +: SETTLE_W];
            ref_pdn_q    <= REG_WDATA_I[REF_PDN_BIT];
            ref_vsel_q   <= REG_WDATA_I[REF_VSEL_BIT];
         end
         if (tim_wr) begin
            pre_sel_q <= REG_WDATA_I[PRE_LSB +: SEL_W];
            sns_sel_q <= REG_WDATA_I[SNS_LSB +: SEL_W];
         end
         if (key_wr) begin
            key_db_q    <= REG_WDATA_I[KEY_DB_LSB +: SEL_W];
            scan_stop_q <= REG_WDATA_I[SCAN_STOP_BIT];
         end
      end
   end

   // Read data is registered; unmapped offsets return zero
   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= REG_RD_I;
         rdata_q  <= '0;
         if (REG_RD_I && key_sel) begin
            rdata_q[KEY_PRESSED_BIT] <= ~key_irq_n;
            rdata_q[SCAN_STOP_BIT]   <= ~ks_busy;
            rdata_q[KEY_DB_LSB +: SEL_W] <= key_db_q;
         end else if (REG_RD_I && ref_sel) begin
            rdata_q[REF_INT_BIT]    <= ref_int_q;
            rdata_q[REF_SETTLE_LSB +: SETTLE_W] <= ref_settle_q;
            rdata_q[REF_PDN_BIT]    <= ref_pdn_q;
            rdata_q[REF_VSEL_BIT]   <= ref_vsel_q;
         end else if (REG_RD_I && tim_sel) begin
            rdata_q[PRE_LSB +: SEL_W] <= pre_sel_q;
            rdata_q[SNS_LSB +: SEL_W] <= sns_sel_q;
         end
      end
   end

   // The internal reference is wanted only when selected, and then either
   // always or just while a conversion is requested
   assign need_ref = ref_int_q && (!ref_pdn_q || CONV_REQ_I);

   always_comb begin
      ref_d = ref_st_q;
      case (ref_st_q)
         REF_OFF: if (need_ref) begin
            ref_d = REF_SETTLE;
         end
         REF_SETTLE: if (!need_ref) begin
            ref_d = REF_OFF;
         end else if (ref_tmr.done) begin
            ref_d = REF_READY;
         end
         REF_READY: if (!need_ref) begin
            ref_d = REF_OFF;
         end
         default: ref_d = REF_OFF;
      endcase
   end

   assign ref_tmr.start  = (ref_st_q == REF_OFF) && need_ref;
   assign ref_tmr.clear  = !need_ref;
   assign ref_tmr.cycles = CNT_W'(SETTLE_CYC_P[ref_settle_q]);

   tkc_timer u_ref_tmr (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .tmr     (ref_tmr.tmr)
   );

   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         ref_st_q  <= REF_OFF;
         ref_pwr_q <= 1'b0;
      end else begin
         ref_st_q  <= ref_d;
         ref_pwr_q <= need_ref;
      end
   end

   // An external reference needs no settling; a stop write drops go at once
   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         conv_go_q <= 1'b0;
         abort_q   <= 1'b0;
      end else begin
         conv_go_q <= CONV_REQ_I && !scan_stop_wr &&
                      (!ref_int_q || (ref_d == REF_READY));
         abort_q   <= scan_stop_wr;
      end
   end

   // Touch detect: precharge phase, then sense phase, then sample the pin
   always_comb begin
      td_d = td_q;
      case (td_q)
         TD_IDLE: if (TOUCH_REQ_I) begin
            td_d = TD_PRE;
         end
         TD_PRE: if (!TOUCH_REQ_I) begin
            td_d = TD_IDLE;
         end else if (td_tmr.done) begin
            td_d = TD_SENSE;
         end
         TD_SENSE: if (!TOUCH_REQ_I || td_tmr.done) begin
            td_d = TD_IDLE;
         end
         default: td_d = TD_IDLE;
      endcase
   end

   assign td_tmr.start  = TOUCH_REQ_I && ((td_q == TD_IDLE) ||
                          ((td_q == TD_PRE) && td_tmr.done));
   assign td_tmr.clear  = !TOUCH_REQ_I;
   assign td_tmr.cycles = (td_q == TD_IDLE) ?
                          CNT_W'(PRE_CYC_P[pre_sel_q]) :
                          CNT_W'(SNS_CYC_P[sns_sel_q]);

   tkc_timer u_td_tmr (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .tmr     (td_tmr.tmr)
   );

   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         td_q     <= TD_IDLE;
         pre_on_q <= 1'b0;
         sns_on_q <= 1'b0;
         touch_q  <= 1'b0;
      end else begin
         td_q     <= td_d;
         pre_on_q <= (td_d == TD_PRE);
         sns_on_q <= (td_d == TD_SENSE);
         if ((td_q == TD_SENSE) && TOUCH_REQ_I && td_tmr.done) begin
            touch_q <= sense_pin;
         end
      end
   end

   tkc_keyscan u_keyscan (
      .clk_i       (CLK_SYS_I),
      .rst_n_i     (rst_n),
      .key_down_i  (key_down),
      .data_read_i (KEY_DATA_READ_I),
      .db_cycles_i (CNT_W'(KEY_DB_CYC_P[key_db_q])),
      .run_i       (!scan_stop_q),
      .stop_i      (scan_stop_wr),
      .busy_o      (ks_busy),
      .irq_n_o     (key_irq_n)
   );

   assign REG_RDATA_O   = rdata_q;
   assign REG_RVALID_O  = rvalid_q;
   assign CONV_GO_O     = conv_go_q;
   assign CONV_ABORT_O  = abort_q;
   assign REF_INT_SEL_O = ref_int_q;
   assign REF_PWR_ON_O  = ref_pwr_q;
   assign REF_2V5_O     = ref_vsel_q;
   assign PRECHARGE_O   = pre_on_q;
   assign SENSE_O       = sns_on_q;
   assign TOUCH_DET_O   = touch_q;
   assign KEY_IRQ_N_O   = key_irq_n;

   // Precharge length, measured for the checks below
   int unsigned pre_hold_q;
   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         pre_hold_q <= 0;
      end else begin
         pre_hold_q <= pre_on_q ? pre_hold_q + 1 : 0;
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!rst_n);

   ext_ref_off_a: assert property (
      !ref_int_q && !$past(ref_int_q) |-> !REF_PWR_ON_O)
      else $error("internal reference on while external selected");
   ref_always_on_a: assert property (
      ref_int_q && !ref_pdn_q |=> REF_PWR_ON_O)
      else $error("reference off with power-down disabled");
   ref_auto_off_a: assert property (
      ref_int_q && ref_pdn_q && !CONV_REQ_I |=> !REF_PWR_ON_O)
      else $error("reference left on between conversions");
   go_after_settle_a: assert property (
      $rose(CONV_GO_O) && $past(ref_int_q) |-> $past(ref_st_q) != REF_OFF
      && $past(ref_tmr.done) || $past(ref_st_q) == REF_READY)
      else $error("conversion started on unsettled reference");
   sense_after_pre_a: assert property (
      $rose(SENSE_O) |-> $past(PRECHARGE_O))
      else $error("sense phase without precharge");
   pre_length_a: assert property (
      $fell(PRECHARGE_O) && SENSE_O |->
      pre_hold_q == PRE_CYC_P[$past(pre_sel_q)])
      else $error("precharge length wrong");
   stop_halts_a: assert property (
      scan_stop_wr |=> !ks_busy && CONV_ABORT_O && !CONV_GO_O)
      else $error("stop write did not halt");
   stop_irq_a: assert property (
      scan_stop_wr |=> KEY_IRQ_N_O [*2])
      else $error("interrupt not released by stop");
   status_inv_a: assert property (
      REG_RVALID_O && $past(REG_RD_I && key_sel) |->
      REG_RDATA_O[KEY_PRESSED_BIT] == !$past(KEY_IRQ_N_O))
      else $error("key status not inverse of interrupt");
   scan_busy_a: assert property (
      REG_RVALID_O && $past(REG_RD_I && key_sel) |->
      REG_RDATA_O[SCAN_STOP_BIT] == $past(!ks_busy))
      else $error("scan status mismatch");
   ref_readback_a: assert property (
      ref_wr ##1 (REG_RD_I && ref_sel && !REG_WR_I) |=>
      REG_RDATA_O[4:0] == $past(REG_WDATA_I[4:0], 2))
      else $error("reference readback mismatch");
   reserved_zero_a: assert property (
      REG_RVALID_O && $past(REG_RD_I && ref_sel) |-> REG_RDATA_O[15:5] == '0)
      else $error("reserved bits not zero");

   conv_go_c: cover property ($rose(CONV_GO_O) && REF_INT_SEL_O);
   touch_c:   cover property ($rose(TOUCH_DET_O));
   key_irq_c: cover property ($fell(KEY_IRQ_N_O));
   stop_c:    cover property (scan_stop_wr && ks_busy);
endmodule // tkc_ctrl_top
`default_nettype wire

// *** include/tkc_pkg.sv ***
package tkc_pkg;
   // Clock and counter sizing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned PAGE_W        = 2;
   localparam int unsigned ADDR_W        = 6;
   localparam int unsigned DATA_W        = 16;
   // Register map
   localparam logic [PAGE_W-1:0] REG_PAGE       = 2'h1;
   localparam logic [ADDR_W-1:0] KEY_CTRL_ADDR  = 6'h01;
   localparam logic [ADDR_W-1:0] REF_CTRL_ADDR  = 6'h03;
   localparam logic [ADDR_W-1:0] TOUCH_TIM_ADDR = 6'h05;
   // Field positions
   localparam int unsigned KEY_PRESSED_BIT = 15;
   localparam int unsigned SCAN_STOP_BIT   = 14;
   localparam int unsigned KEY_DB_LSB      = 11;
   localparam int unsigned REF_INT_BIT     = 4;
   localparam int unsigned REF_SETTLE_LSB  = 2;
   localparam int unsigned REF_PDN_BIT     = 1;
   localparam int unsigned REF_VSEL_BIT    = 0;
   localparam int unsigned PRE_LSB         = 3;
   localparam int unsigned SNS_LSB         = 0;
   localparam int unsigned SETTLE_W        = 2;
   localparam int unsigned SEL_W           = 3;
   // Reset values
   localparam logic                REF_INT_RST    = 1'b0;
   localparam logic [SETTLE_W-1:0] REF_SETTLE_RST = 2'h0;
   localparam logic                REF_PDN_RST    = 1'b1;
   localparam logic                REF_VSEL_RST   = 1'b0;
   localparam logic [SEL_W-1:0]    PRE_RST        = 3'h0;
   localparam logic [SEL_W-1:0]    SNS_RST        = 3'h0;
   localparam logic [SEL_W-1:0]    KEY_DB_RST     = 3'h0;
   localparam logic                SCAN_STOP_RST  = 1'b0;
   // Timing tables
   typedef int unsigned tkc_tab4_t [4];
   typedef int unsigned tkc_tab8_t [8];
   localparam tkc_tab4_t SETTLE_TIME_US = '{0, 100, 500, 1000};
   localparam tkc_tab8_t PRE_TIME_US    = '{20, 84, 276, 340,
                                            1044, 1108, 1300, 1364};
   localparam tkc_tab8_t SNS_TIME_US    = '{32, 96, 544, 608,
                                            2080, 2144, 2592, 2656};
   localparam tkc_tab8_t KEY_DB_TIME_MS = '{2, 10, 20, 50, 60, 80, 100, 120};
   // Least times: round up, never below one cycle
   function automatic int unsigned tkc_ns2cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction
   function automatic tkc_tab4_t tkc_cyc4(input tkc_tab4_t t,
                                          input int unsigned ns_per);
      tkc_tab4_t r;
      for (int i = 0; i < 4; i++) r[i] = tkc_ns2cyc(t[i] * ns_per);
      return r;
   endfunction
   function automatic tkc_tab8_t tkc_cyc8(input tkc_tab8_t t,
                                          input int unsigned ns_per);
      tkc_tab8_t r;
      for (int i = 0; i < 8; i++) r[i] = tkc_ns2cyc(t[i] * ns_per);
      return r;
   endfunction
   localparam tkc_tab4_t SETTLE_CYC = tkc_cyc4(SETTLE_TIME_US, 1000);
   localparam tkc_tab8_t PRE_CYC    = tkc_cyc8(PRE_TIME_US, 1000);
   localparam tkc_tab8_t SNS_CYC    = tkc_cyc8(SNS_TIME_US, 1000);
   localparam tkc_tab8_t KEY_DB_CYC = tkc_cyc8(KEY_DB_TIME_MS, 1000000);
   // State encodings
   typedef enum logic [1:0] {
      REF_OFF = 2'b00, REF_SETTLE = 2'b01, REF_READY = 2'b10
   } tkc_ref_st_t;
   typedef enum logic [1:0] {
      TD_IDLE = 2'b00, TD_PRE = 2'b01, TD_SENSE = 2'b10
   } tkc_td_st_t;
   typedef enum logic [1:0] {
      KS_IDLE = 2'b00, KS_DEBOUNCE = 2'b01, KS_SCAN = 2'b10
   } tkc_ks_st_t;
endpackage

// *** include/tkc_tmr_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface tkc_tmr_if;
   import tkc_pkg::*;
   logic             start;
   logic             clear;
   logic [CNT_W-1:0] cycles;
   logic             busy;
   logic             done;
   modport ctl (output start, output clear, output cycles,
                input busy, input done);
   modport tmr (input start, input clear, input cycles,
                output busy, output done);
endinterface
`default_nettype wire

// *** verilog/tkc_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module tkc_timer (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Control side
   tkc_tmr_if.tmr    tmr
);
   import tkc_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic             busy_q;

   // Done is high in the last counted cycle, so a phase lasts cycles exactly
   assign tmr.done = busy_q && (cnt_q == CNT_W'(1));
   assign tmr.busy = busy_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
      end else if (tmr.clear) begin
         busy_q <= 1'b0;
      end else if (tmr.start) begin
         cnt_q  <= tmr.cycles;
         busy_q <= 1'b1;
      end else if (tmr.done) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q  <= cnt_q - 1'b1;
      end
   end
endmodule // tkc_timer
`default_nettype wire

// *** verilog/tkc_keyscan.sv ***
`timescale 1ns/10ps
`default_nettype none
module tkc_keyscan (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   // Keypad events
   input  wire logic                     key_down_i,
   input  wire logic                     data_read_i,
   // Control
   input  wire logic [tkc_pkg::CNT_W-1:0] db_cycles_i,
   input  wire logic                     run_i,
   input  wire logic                     stop_i,
   // Status
   output logic                          busy_o,
   output logic                          irq_n_o
);
   import tkc_pkg::*;

   tkc_ks_st_t       st_q;
   logic [CNT_W-1:0] cnt_q;
   logic             db_done;

   assign db_done = (st_q == KS_DEBOUNCE) && key_down_i && !stop_i &&
                    (cnt_q <= CNT_W'(1));
   assign busy_o  = (st_q != KS_IDLE);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q  <= KS_IDLE;
         cnt_q <= '0;
      end else if (stop_i) begin
         st_q  <= KS_IDLE;
      end else begin
         case (st_q)
            KS_IDLE: if (run_i && key_down_i) begin
               st_q  <= KS_DEBOUNCE;
               cnt_q <= db_cycles_i;
            end
            KS_DEBOUNCE: if (!key_down_i) begin
               st_q <= KS_IDLE;
            end else if (db_done) begin
               st_q <= KS_SCAN;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            // Scans repeat while the key stays down
            KS_SCAN: if (!key_down_i || !run_i) begin
               st_q <= KS_IDLE;
            end
            default: st_q <= KS_IDLE;
         endcase
      end
   end

   // A debounce completing wins over a data read in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_o <= 1'b1;
      end else if (db_done) begin
         irq_n_o <= 1'b0;
      end else if (stop_i || data_read_i) begin
         irq_n_o <= 1'b1;
      end
   end
endmodule // tkc_keyscan
`default_nettype wire

// *** sim/touch_adc_ref_keypad_ctrl_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module touch_adc_ref_keypad_ctrl_bench;
   import tkc_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [PAGE_W-1:0] page = 2'h1;
   logic [ADDR_W-1:0] addr = 6'h00;
   logic [DATA_W-1:0] wdata = 16'h0000;
   logic [DATA_W-1:0] rdata;
   logic              wr = 1'b0, rd = 1'b0, creq = 1'b0, treq = 1'b0;
   logic              tsen = 1'b0, kdn = 1'b0, kread = 1'b0;
   logic              rvalid, go, abort, intsel, pwr, v25;
   logic              pre, sns, tdet, irq_n;
   int                n_mismatch = 0;
   int                n_checks = 0;
   int                k;

   initial begin
      forever #25 clk = ~clk;
   end

   // Short tables keep every timed phase to a few cycles
   tkc_ctrl_top #(
      .SETTLE_CYC_P ('{1, 2, 3, 4}),
      .PRE_CYC_P    ('{2, 3, 4, 5, 6, 7, 8, 9}),
      .SNS_CYC_P    ('{2, 3, 4, 5, 6, 7, 8, 9}),
      .KEY_DB_CYC_P ('{3, 4, 5, 6, 7, 8, 9, 10})
   ) u_dut (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_PAGE_I(page),
      .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .CONV_REQ_I(creq), .CONV_GO_O(go), .CONV_ABORT_O(abort),
      .REF_INT_SEL_O(intsel), .REF_PWR_ON_O(pwr), .REF_2V5_O(v25),
      .TOUCH_REQ_I(treq), .TOUCH_SENSE_I(tsen), .PRECHARGE_O(pre),
      .SENSE_O(sns), .TOUCH_DET_O(tdet), .KEY_DOWN_I(kdn),
      .KEY_DATA_READ_I(kread), .KEY_IRQ_N_O(irq_n)
   );

   task automatic test_done;
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd16(input logic [ADDR_W-1:0] a,
                       input logic [15:0] m, e, input string nm);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("rvalid", 16'h0001, 16'(rvalid));
      chk(nm, e, rdata & m);
   endtask

   // Bounded wait: a hang ends the run as a failure
   task automatic wt(ref logic s, input logic v);
      for (k = 0; k < 300 && s !== v; k++) @(negedge clk);
      if (k == 300) begin
         n_mismatch++;
         $display("mismatch wait exp %b got %b", v, s);
         test_done();
      end
   endtask

   task automatic cnt(ref logic s, output int c);
      c = 0;
      while (s === 1'b1 && c < 300) begin
         @(negedge clk);
         c++;
      end
   endtask

   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      rd16(REF_CTRL_ADDR, 16'hffff, 16'h0002, "ref");
      rd16(TOUCH_TIM_ADDR, 16'hffff, 16'h0000, "tim");
      rd16(KEY_CTRL_ADDR, 16'hffff, 16'h4000, "key");
      rd16(6'h02, 16'hffff, 16'h0000, "unmapped");
      page = 2'h0;
      rd16(REF_CTRL_ADDR, 16'hffff, 16'h0000, "page0");
      page = 2'h1;
      wr16(REF_CTRL_ADDR, 16'hffff);
      rd16(REF_CTRL_ADDR, 16'hffff, 16'h001f, "ref");
      chk("int_v25", 16'h0003, 16'({intsel, v25}));
      wr16(TOUCH_TIM_ADDR, 16'hffff);
      rd16(TOUCH_TIM_ADDR, 16'hffff, 16'h003f, "tim");
      wr16(KEY_CTRL_ADDR, 16'hb800);
      rd16(KEY_CTRL_ADDR, 16'hffff, 16'h7800, "key");
      wr16(KEY_CTRL_ADDR, 16'h0000);
      // Internal reference, delay code 01, power-down between conversions
      wr16(REF_CTRL_ADDR, 16'h0016);
      creq = 1'b1;
      @(negedge clk);
      chk("pwr", 16'h0001, 16'(pwr));
      for (k = 1; k < 300 && go !== 1'b1; k++) @(negedge clk);
      chk("settle", 16'h0003, 16'(k));
      creq = 1'b0;
      repeat (2) @(negedge clk);
      chk("pwr", 16'h0000, 16'(pwr));
      wr16(REF_CTRL_ADDR, 16'h0010);
      @(negedge clk);
      chk("pwr", 16'h0001, 16'(pwr));
      wr16(REF_CTRL_ADDR, 16'h0000);
      creq = 1'b1;
      repeat (2) @(negedge clk);
      chk("pwr_go", 16'h0001, 16'({pwr, go}));
      // Precharge code 1 then sense code 2
      wr16(TOUCH_TIM_ADDR, 16'h000a);
      tsen = 1'b1;
      treq = 1'b1;
      wt(pre, 1'b1);
      cnt(pre, k);
      chk("pre", 16'h0003, 16'(k));
      cnt(sns, k);
      chk("sns", 16'h0004, 16'(k));
      chk("det", 16'h0001, 16'(tdet));
      treq = 1'b0;
      kdn = 1'b1;
      wt(irq_n, 1'b0);
      rd16(KEY_CTRL_ADDR, 16'h8000, 16'h8000, "pressed");
      kdn = 1'b0;
      kread = 1'b1;
      @(negedge clk);
      kread = 1'b0;
      @(negedge clk);
      kdn = 1'b1;
      wt(irq_n, 1'b0);
      wr16(KEY_CTRL_ADDR, 16'h4000);
      chk("stop", 16'h0003, 16'({abort, irq_n}));
      chk("go", 16'h0000, 16'(go));
      repeat (20) @(negedge clk);
      chk("irq_n", 16'h0001, 16'(irq_n));
      rd16(KEY_CTRL_ADDR, 16'hc000, 16'h4000, "key");
      test_done();
   end
endmodule // touch_adc_ref_keypad_ctrl_bench
`default_nettype wire
